// ### pattern_channel_compare_logic.sv
// per-channel vector logic: accumulators, driver formats, strobe, compare, fail capture
// assumes synchronous receiver inputs and an avalon-mm master that holds requests
`timescale 1ns/1ps
`default_nettype none
module pattern_channel_compare_logic (
	input  wire logic        clock,
	input  wire logic        ce,
	input  wire logic        rstn,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest,
	input  wire logic [31:0] rx_normal,
	input  wire logic [31:0] rx_detect,
	input  wire logic [3:0]  global_carry_in,
	output var  logic [31:0] pin_out,
	output var  logic [31:0] pin_oe_n,
	output var  logic [3:0]  global_carry_out,
	output var  logic        irq
);
	typedef enum logic {st_idle, st_run} run_state_e;

	function automatic pattern_channel_pkg::word_t be_merge(
		input pattern_channel_pkg::word_t old_v,
		input pattern_channel_pkg::word_t new_v,
		input logic [3:0]                 be
	);
		pattern_channel_pkg::word_t r;
		for (int b = 0; b < 4; b++) begin
			r[b*8 +: 8] = be[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
		end
		return r;
	endfunction

	// one driver bit for the current phase
	function automatic logic fmt_bit(
		input pattern_channel_pkg::format_s f,
		input logic                         d,
		input logic                         active
	);
		logic v;
		v = d;
		if (!active) begin
			unique case (f.kind)
				pattern_channel_pkg::return_low_format:        v = 1'b0;
				pattern_channel_pkg::return_high_format:       v = 1'b1;
				pattern_channel_pkg::return_complement_format: v = ~d;
				pattern_channel_pkg::hold_level_format:        v = d;
			endcase
		end
		return v ^ f.invert;
	endfunction

	// bus and configuration state
	logic                        wait_reg,      wait_next;
	logic [31:0]                 rdata_reg,     rdata_next;
	logic [31:0]                 ctrl_reg,      ctrl_next;
	pattern_channel_pkg::timing_s timing_reg,   timing_next;
	logic [7:0]                  vec_count_reg, vec_count_next;
	logic [31:0]                 inhibit_reg,   inhibit_next;
	logic [31:0]                 drive_en_reg,  drive_en_next;
	logic [2:0]                  status_reg,    status_next;
	logic [2:0]                  mask_reg,      mask_next;
	logic                        irq_reg,       irq_next;
	logic [3:0]                  index_reg,     index_next;
	pattern_channel_pkg::acc_cfg_s cfg_reg [4];
	pattern_channel_pkg::acc_cfg_s cfg_next [4];
	logic [31:0]                 drv_mem [16];
	logic [31:0]                 drv_mem_next [16];
	logic [31:0]                 exp_mem [16];
	logic [31:0]                 exp_mem_next [16];

	// run engine state
	run_state_e                  st_reg,        st_next;
	logic [3:0]                  phase_reg,     phase_next;
	logic [7:0]                  vec_reg,       vec_next;
	logic [7:0]                  acc_reg [4];
	logic [7:0]                  acc_next [4];
	logic [3:0]                  carry_reg,     carry_next;
	logic [15:0]                 fail_cnt_reg,  fail_cnt_next;
	logic [31:0]                 fail_addr_reg, fail_addr_next;
	logic [31:0]                 fail_data_reg, fail_data_next;
	logic [15:0]                 nml_cnt_reg,   nml_cnt_next;
	logic [31:0]                 pin_reg,       pin_next;
	logic [31:0]                 oe_n_reg,      oe_n_next;
	logic [31:0]                 res_mem [16];
	logic [31:0]                 res_mem_next [16];
	logic [31:0]                 det_mem [16];
	logic [31:0]                 det_mem_next [16];

	logic       accept;
	logic       start_pulse;
	logic [2:0] events;
	logic [3:0] mem_idx;

	assign avs_readdata     = rdata_reg;
	assign avs_waitrequest  = wait_reg;
	assign pin_out          = pin_reg;
	assign pin_oe_n         = oe_n_reg;
	assign global_carry_out = carry_reg;
	assign irq              = irq_reg;

	// one wait cycle: the read mux is registered while waitrequest is high
	assign accept      = (avs_read | avs_write) & ~wait_reg;
	assign start_pulse = accept & avs_write & (avs_address == pattern_channel_pkg::OFF_CTRL)
		& avs_byteenable[0] & avs_writedata[pattern_channel_pkg::CTRL_START_BIT];

	always_comb begin
		pattern_channel_pkg::word_t wv;
		logic [1:0]                 a;
		wv             = 32'h0000_0000;
		a              = avs_address[3:2];
		wait_next      = ~((avs_read | avs_write) & wait_reg);
		rdata_next     = rdata_reg;
		ctrl_next      = ctrl_reg;
		timing_next    = timing_reg;
		vec_count_next = vec_count_reg;
		inhibit_next   = inhibit_reg;
		drive_en_next  = drive_en_reg;
		mask_next      = mask_reg;
		index_next     = index_reg;
		cfg_next       = cfg_reg;
		drv_mem_next   = drv_mem;
		exp_mem_next   = exp_mem;
		status_next    = status_reg;
		if (avs_read & wait_reg) begin
			rdata_next = 32'h0000_0000;
			unique case (avs_address)
				pattern_channel_pkg::OFF_CTRL:       rdata_next = ctrl_reg & 32'hffff_fffe;
				pattern_channel_pkg::OFF_TIMING:     rdata_next = {16'h0000, timing_reg};
				pattern_channel_pkg::OFF_VEC_COUNT:  rdata_next = {24'h000000, vec_count_reg};
				pattern_channel_pkg::OFF_INHIBIT:    rdata_next = inhibit_reg;
				pattern_channel_pkg::OFF_DRIVE_EN:   rdata_next = drive_en_reg;
				pattern_channel_pkg::OFF_IRQ_STATUS: rdata_next = {29'h0, status_reg};
				pattern_channel_pkg::OFF_IRQ_MASK:   rdata_next = {29'h0, mask_reg};
				pattern_channel_pkg::OFF_FAIL_COUNT: rdata_next = {16'h0000, fail_cnt_reg};
				pattern_channel_pkg::OFF_FAIL_ADDR:  rdata_next = fail_addr_reg;
				pattern_channel_pkg::OFF_FAIL_DATA:  rdata_next = fail_data_reg;
				pattern_channel_pkg::OFF_NML_COUNT:  rdata_next = {16'h0000, nml_cnt_reg};
				pattern_channel_pkg::OFF_RUN_STATUS: rdata_next = {23'h0, vec_reg, st_reg == st_run};
				pattern_channel_pkg::OFF_MEM_INDEX:  rdata_next = {28'h0, index_reg};
				pattern_channel_pkg::OFF_DRV_DATA:   rdata_next = drv_mem[index_reg];
				pattern_channel_pkg::OFF_EXP_DATA:   rdata_next = exp_mem[index_reg];
				pattern_channel_pkg::OFF_RES_DATA:   rdata_next = res_mem[index_reg];
				pattern_channel_pkg::OFF_DET_DATA:   rdata_next = det_mem[index_reg];
				default: begin
					if (avs_address >= pattern_channel_pkg::OFF_ACC0 &&
						avs_address <= pattern_channel_pkg::OFF_ACC3 && avs_address[1:0] == 2'h0) begin
						rdata_next = {8'h00, acc_reg[a], 4'h0, cfg_reg[a]};
					end
				end
			endcase
		end
		if (accept & avs_write) begin
			unique case (avs_address)
				pattern_channel_pkg::OFF_CTRL: begin
					ctrl_next = be_merge(ctrl_reg, avs_writedata, avs_byteenable);
				end
				pattern_channel_pkg::OFF_TIMING: begin
					wv          = be_merge({16'h0000, timing_reg}, avs_writedata, avs_byteenable);
					timing_next = wv[15:0];
				end
				pattern_channel_pkg::OFF_VEC_COUNT: begin
					if (avs_byteenable[0]) begin
						vec_count_next = avs_writedata[7:0];
					end
				end
				pattern_channel_pkg::OFF_INHIBIT: begin
					inhibit_next = be_merge(inhibit_reg, avs_writedata, avs_byteenable);
				end
				pattern_channel_pkg::OFF_DRIVE_EN: begin
					drive_en_next = be_merge(drive_en_reg, avs_writedata, avs_byteenable);
				end
				pattern_channel_pkg::OFF_IRQ_MASK: begin
					if (avs_byteenable[0]) begin
						mask_next = avs_writedata[2:0];
					end
				end
				pattern_channel_pkg::OFF_MEM_INDEX: begin
					if (avs_byteenable[0]) begin
						index_next = avs_writedata[3:0];
					end
				end
				pattern_channel_pkg::OFF_DRV_DATA: begin
					drv_mem_next[index_reg] = be_merge(drv_mem[index_reg], avs_writedata, avs_byteenable);
				end
				pattern_channel_pkg::OFF_EXP_DATA: begin
					exp_mem_next[index_reg] = be_merge(exp_mem[index_reg], avs_writedata, avs_byteenable);
				end
				default: begin
					if (avs_address >= pattern_channel_pkg::OFF_ACC0 &&
						avs_address <= pattern_channel_pkg::OFF_ACC3 && avs_address[1:0] == 2'h0) begin
						wv          = be_merge({20'h00000, cfg_reg[a]}, avs_writedata, avs_byteenable);
						cfg_next[a] = wv[11:0];
					end
				end
			endcase
		end
		// clear only what the read returned, and a new event still wins
		if (accept & avs_read & (avs_address == pattern_channel_pkg::OFF_IRQ_STATUS)) begin
			status_next = status_reg & ~rdata_reg[2:0];
		end
		status_next = status_next | events;
		irq_next    = |(status_reg & mask_reg);
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wait_reg      <= 1'b1;
			rdata_reg     <= 32'h0000_0000;
			ctrl_reg      <= pattern_channel_pkg::CTRL_RESET;
			timing_reg    <= pattern_channel_pkg::TIMING_RESET;
			vec_count_reg <= pattern_channel_pkg::VEC_RESET;
			inhibit_reg   <= 32'h0000_0000;
			drive_en_reg  <= 32'h0000_0000;
			status_reg    <= 3'h0;
			mask_reg      <= 3'h0;
			irq_reg       <= 1'b0;
			index_reg     <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				cfg_reg[i] <= 12'h000;
			end
			for (int i = 0; i < 16; i++) begin
				drv_mem[i] <= 32'h0000_0000;
				exp_mem[i] <= 32'h0000_0000;
			end
		end else if (ce) begin
			wait_reg      <= wait_next;
			rdata_reg     <= rdata_next;
			ctrl_reg      <= ctrl_next;
			timing_reg    <= timing_next;
			vec_count_reg <= vec_count_next;
			inhibit_reg   <= inhibit_next;
			drive_en_reg  <= drive_en_next;
			status_reg    <= status_next;
			mask_reg      <= mask_next;
			irq_reg       <= irq_next;
			index_reg     <= index_next;
			cfg_reg       <= cfg_next;
			drv_mem       <= drv_mem_next;
			exp_mem       <= exp_mem_next;
		end
	end

	// address follows the low four bits of accumulator zero in every mode, so with a step of one in linear mode each of up to 16 vectors has its own slot
	assign mem_idx = acc_reg[0][3:0];

	always_comb begin
		pattern_channel_pkg::format_s f;
		logic        tick;
		logic        strobe;
		logic        active;
		logic        trig;
		logic [8:0]  sum;
		logic [31:0] unequal;
		logic [31:0] nml;
		logic [3:0]  s;
		f              = ctrl_reg[pattern_channel_pkg::CTRL_FMT_LSB +: 3];
		tick           = (st_reg == st_run) && (phase_reg == timing_reg.period);
		strobe         = (st_reg == st_run) && (phase_reg == timing_reg.strobe);
		active         = (phase_reg >= timing_reg.drv_start) && (phase_reg < timing_reg.drv_end);
		trig           = 1'b0;
		sum            = 9'h000;
		s              = 4'h0;
		unequal        = (rx_normal ^ exp_mem[mem_idx]) & ~inhibit_reg & ~drive_en_reg;
		nml            = rx_normal & rx_detect & ~drive_en_reg;
		st_next        = st_reg;
		phase_next     = phase_reg;
		vec_next       = vec_reg;
		acc_next       = acc_reg;
		carry_next     = 4'h0;
		fail_cnt_next  = fail_cnt_reg;
		fail_addr_next = fail_addr_reg;
		fail_data_next = fail_data_reg;
		nml_cnt_next   = nml_cnt_reg;
		res_mem_next   = res_mem;
		det_mem_next   = det_mem;
		events         = 3'h0;
		pin_next       = pin_reg;
		oe_n_next      = 32'hffff_ffff;
		if (st_reg == st_run) begin
			phase_next = tick ? 4'h0 : phase_reg + 4'h1;
			oe_n_next  = ~drive_en_reg;
			for (int c = 0; c < 32; c++) begin
				pin_next[c] = fmt_bit(f, drv_mem[mem_idx][c], active);
			end
			for (int i = 0; i < 4; i++) begin
				s    = cfg_reg[i].src;
				trig = 1'b0;
				if (s == pattern_channel_pkg::SRC_TICK) begin
					trig = tick;
				end else if (s >= pattern_channel_pkg::SRC_LOCAL && s < pattern_channel_pkg::SRC_GLOBAL) begin
					trig = carry_reg[2'(s - pattern_channel_pkg::SRC_LOCAL)];
				end else if (s >= pattern_channel_pkg::SRC_GLOBAL && s < 4'ha) begin
					trig = global_carry_in[2'(s - pattern_channel_pkg::SRC_GLOBAL)];
				end
				if (trig) begin
					sum = {1'b0, acc_reg[i]} + {1'b0, cfg_reg[i].addend};
					if (i == 0 && !ctrl_reg[pattern_channel_pkg::CTRL_LINEAR_BIT] &&
						acc_reg[0] >= ctrl_reg[pattern_channel_pkg::CTRL_LOOP_LSB +: 8]) begin
						sum = 9'h100;
					end
					acc_next[i]   = sum[7:0];
					carry_next[i] = sum[8];
				end
			end
			if (strobe) begin
				res_mem_next[mem_idx] = rx_normal;
				det_mem_next[mem_idx] = rx_normal & rx_detect;
				if (|unequal) begin
					fail_cnt_next  = fail_cnt_reg + 16'h0001;
					fail_addr_next = {acc_reg[3], acc_reg[2], acc_reg[1], acc_reg[0]};
					fail_data_next = rx_normal;
					events[pattern_channel_pkg::IRQ_FAIL_BIT] = 1'b1;
				end
				if (|nml) begin
					nml_cnt_next = nml_cnt_reg + 16'h0001;
					events[pattern_channel_pkg::IRQ_NML_BIT] = 1'b1;
				end
			end
			if (tick) begin
				vec_next = vec_reg + 8'h01;
				if (vec_reg + 8'h01 >= vec_count_reg) begin
					st_next = st_idle;
					events[pattern_channel_pkg::IRQ_DONE_BIT] = 1'b1;
				end
			end
		end
		if (start_pulse) begin
			st_next        = st_run;
			phase_next     = 4'h0;
			vec_next       = 8'h00;
			acc_next       = '{default: 8'h00};
			fail_cnt_next  = 16'h0000;
			fail_addr_next = 32'h0000_0000;
			fail_data_next = 32'h0000_0000;
			nml_cnt_next   = 16'h0000;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_reg        <= st_idle;
			phase_reg     <= 4'h0;
			vec_reg       <= 8'h00;
			carry_reg     <= 4'h0;
			fail_cnt_reg  <= 16'h0000;
			fail_addr_reg <= 32'h0000_0000;
			fail_data_reg <= 32'h0000_0000;
			nml_cnt_reg   <= 16'h0000;
			pin_reg       <= 32'h0000_0000;
			oe_n_reg      <= 32'hffff_ffff;
			for (int i = 0; i < 4; i++) begin
				acc_reg[i] <= 8'h00;
			end
			for (int i = 0; i < 16; i++) begin
				res_mem[i] <= 32'h0000_0000;
				det_mem[i] <= 32'h0000_0000;
			end
		end else if (ce) begin
			st_reg        <= st_next;
			phase_reg     <= phase_next;
			vec_reg       <= vec_next;
			carry_reg     <= carry_next;
			fail_cnt_reg  <= fail_cnt_next;
			fail_addr_reg <= fail_addr_next;
			fail_data_reg <= fail_data_next;
			nml_cnt_reg   <= nml_cnt_next;
			pin_reg       <= pin_next;
			oe_n_reg      <= oe_n_next;
			acc_reg       <= acc_next;
			res_mem       <= res_mem_next;
			det_mem       <= det_mem_next;
		end
	end
endmodule
`default_nettype wire

// ### pattern_channel_pkg.sv
// constants, register map and carrier types of the pattern channel logic
// assumes a 32-bit avalon-mm slave port and one 20 MHz clock that is also the edge clock
package pattern_channel_pkg;

	localparam int CHANNELS = 32;
	localparam int NUM_ACC  = 4;
	localparam int ACC_W    = 8;
	localparam int DEPTH    = 16;
	localparam int IDX_W    = 4;
	localparam int PH_W     = 4;
	localparam int CNT_W    = 16;
	localparam int IRQ_W    = 3;

	typedef logic [31:0] word_t;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL       = 8'h00;
	localparam logic [7:0] OFF_TIMING     = 8'h04;
	localparam logic [7:0] OFF_VEC_COUNT  = 8'h08;
	localparam logic [7:0] OFF_INHIBIT    = 8'h0c;
	localparam logic [7:0] OFF_DRIVE_EN   = 8'h10;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK   = 8'h18;
	localparam logic [7:0] OFF_FAIL_COUNT = 8'h1c;
	localparam logic [7:0] OFF_FAIL_ADDR  = 8'h20;
	localparam logic [7:0] OFF_FAIL_DATA  = 8'h24;
	localparam logic [7:0] OFF_NML_COUNT  = 8'h28;
	localparam logic [7:0] OFF_RUN_STATUS = 8'h2c;
	localparam logic [7:0] OFF_ACC0       = 8'h40;
	localparam logic [7:0] OFF_ACC3       = 8'h4c;
	localparam logic [7:0] OFF_MEM_INDEX  = 8'h50;
	localparam logic [7:0] OFF_DRV_DATA   = 8'h54;
	localparam logic [7:0] OFF_EXP_DATA   = 8'h58;
	localparam logic [7:0] OFF_RES_DATA   = 8'h5c;
	localparam logic [7:0] OFF_DET_DATA   = 8'h60;

	// field positions
	localparam int CTRL_START_BIT  = 0;
	localparam int CTRL_LINEAR_BIT = 1;
	localparam int CTRL_FMT_LSB    = 4;
	localparam int CTRL_LOOP_LSB   = 8;
	localparam int ACC_VALUE_LSB   = 16;
	localparam int IRQ_DONE_BIT    = 0;
	localparam int IRQ_FAIL_BIT    = 1;
	localparam int IRQ_NML_BIT     = 2;

	// reset values
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0002;
	localparam logic [15:0] TIMING_RESET = 16'h3804;
	localparam logic [7:0]  VEC_RESET    = 8'h10;

	// carry source select codes
	localparam logic [3:0] SRC_NONE   = 4'h0;
	localparam logic [3:0] SRC_TICK   = 4'h1;
	localparam logic [3:0] SRC_LOCAL  = 4'h2;
	localparam logic [3:0] SRC_GLOBAL = 4'h6;

	typedef enum logic [1:0] {
		return_low_format        = 2'h0,
		return_high_format       = 2'h1,
		return_complement_format = 2'h2,
		hold_level_format        = 2'h3
	} format_e;

	typedef struct packed {
		logic    invert;
		format_e kind;
	} format_s;

	// all counts in edge clock periods
	typedef struct packed {
		logic [PH_W-1:0] strobe;
		logic [PH_W-1:0] drv_end;
		logic [PH_W-1:0] drv_start;
		logic [PH_W-1:0] period;
	} timing_s;

	typedef struct packed {
		logic [3:0]       src;
		logic [ACC_W-1:0] addend;
	} acc_cfg_s;

endpackage

// ### selftest_card_model.sv
// selftest card model: upper and lower channel halves are looped onto each other
// assumes registered pin outputs of the block; undriven receivers float high
`timescale 1ns/1ps
`default_nettype none
module selftest_card_model (
	input  wire logic [31:0] pin_out,
	input  wire logic [31:0] pin_oe_n,
	output var  logic [31:0] rx_normal,
	output var  logic [31:0] rx_detect
);
	logic en;
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			// control channels 28 to 30 gate one byte each and 31 gates channels 24 to 27, so a byte can be left floating
			en = !pin_oe_n[i ^ 16] && (i >= 28 || (!pin_oe_n[28 + i / 8] && pin_out[28 + i / 8]));
			rx_normal[i] = en ? pin_out[i ^ 16] : 1'b1;
			rx_detect[i] = en ? ~pin_out[i ^ 16] : 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### pattern_channel_asserts.sv
// port checker: bus handshake, reset state, carry pulses, interrupt clearing
// assumes one clock domain and a bind onto the block's top module
`timescale 1ns/1ps
`default_nettype none
module pattern_channel_checker (
	input wire logic        clock,
	input wire logic        ce,
	input wire logic        rstn,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [7:0]  avs_address,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [31:0] pin_oe_n,
	input wire logic [3:0]  global_carry_out,
	input wire logic        irq
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	wire logic req = avs_read | avs_write;
	AST_WAIT_ONE: assert property (!avs_waitrequest && ce |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_WAIT_ANSWER: assert property (req && avs_waitrequest && ce |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	AST_WAIT_IDLE: assert property (!req && ce |=> avs_waitrequest)
		else $error("waitrequest low without a request");
	AST_UNMAPPED_ZERO: assert property (avs_read && avs_waitrequest && ce && avs_address[7:4] == 4'h3
		|=> avs_readdata == 32'h0) else $error("unmapped read not zero");
	AST_DATA_HOLD: assert property (avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
		else $error("read data moved outside an answer");
	AST_RESET_STATE: assert property ($rose(rstn) |-> avs_waitrequest && pin_oe_n == '1
		&& global_carry_out == 4'h0 && !irq) else $error("outputs not idle after reset");
	AST_CARRY_PULSE: assert property (global_carry_out[0] |=> !global_carry_out[0])
		else $error("carry out longer than one cycle");
	AST_IRQ_CLEAR: assert property ($fell(irq) |-> !$past(avs_waitrequest, 2))
		else $error("interrupt dropped without a bus access");
	cover property (avs_read && !avs_waitrequest);
	cover property ($rose(irq));
	cover property (global_carry_out[0]);
endmodule
bind pattern_channel_compare_logic pattern_channel_checker u_checker (.clock, .ce, .rstn, .avs_read,
	.avs_write, .avs_address, .avs_readdata, .avs_waitrequest, .pin_oe_n, .global_carry_out, .irq);
`default_nettype wire

// ### tb_pattern_channel_compare_logic.sv
// self-checking bench: pattern runs through the selftest card model with random data
// assumes the card model and the checker are compiled first; carries loop back to inputs
`timescale 1ns/1ps
`default_nettype none
module tb_pattern_channel_compare_logic;
	logic        clock = 0, rstn = 0, ce = 1, avs_read = 0, avs_write = 0, avs_waitrequest, irq;
	logic [7:0]  avs_address = 8'h00;
	logic [3:0]  avs_byteenable = 4'hf, global_carry_out;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, pin_out, pin_oe_n, rx_normal, rx_detect;
	logic [31:0] q, mask, acc;
	int          err_count = 0, checked = 0, pulses = 0, p0, ncar;
	always #25 clock = ~clock;
	always @(posedge clock) pulses <= pulses + int'(global_carry_out[0]);
	pattern_channel_compare_logic uut (.clock, .ce, .rstn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_normal, .rx_detect,
		.global_carry_in(global_carry_out), .pin_out, .pin_oe_n, .global_carry_out, .irq);
	selftest_card_model card (.pin_out, .pin_oe_n, .rx_normal, .rx_detect);
	task automatic end_of_test;
		if (err_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		n = 0;
		// waitrequest and read data are both taken at the same rising edge
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (n >= 100) begin
			$display("[FAIL] %0t bus timeout", $time);
			err_count++;
			end_of_test();
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic read_accs;
		for (int k = 0; k < 4; k++) begin
			bus(0, pattern_channel_pkg::OFF_ACC0 + 8'(4 * k), 0);
			acc[8 * k +: 8] = q[23:16];
		end
	endtask
	task automatic start_wait(input logic [31:0] ctrl);
		int n;
		bus(1, pattern_channel_pkg::OFF_CTRL, ctrl);
		n = 0;
		do begin
			bus(0, pattern_channel_pkg::OFF_RUN_STATUS, 0);
			n++;
		end while (q[0] !== 1'b0 && n < 200);
		if (n >= 200) begin
			$display("[FAIL] %0t run never finished", $time);
			err_count++;
			end_of_test();
		end
	endtask
	// what the card returns for one vector: {detect, normal}, with 0xffff0000 driving
	function automatic logic [63:0] card_rx(input logic [31:0] d, input logic [2:0] f,
			input logic act);
		logic [31:0] v, rx, dt;
		logic        drv;
		v = act ? d : (f[1:0] == 2'h0 ? 32'h0 : f[1:0] == 2'h1 ? '1 : f[1:0] == 2'h2 ? ~d : d);
		v = f[2] ? ~v : v;
		for (int i = 0; i < 32; i++) begin
			drv = i < 16 && v[28 + i / 8];
			rx[i] = drv ? v[i ^ 16] : 1'b1;
			dt[i] = drv ? ~v[i ^ 16] : 1'b1;
		end
		return {dt, rx};
	endfunction
	task automatic run(input int n, input logic [2:0] f, input logic [15:0] tim,
			input logic all_fail, input logic [31:0] inh);
		logic [31:0] rx[16], dt[16], d, e, fa, fd, st;
		logic [63:0] c;
		int          nf, nm;
		nf = 0;
		nm = 0;
		bus(1, pattern_channel_pkg::OFF_TIMING, 32'(tim));
		bus(1, pattern_channel_pkg::OFF_VEC_COUNT, n);
		bus(1, pattern_channel_pkg::OFF_INHIBIT, inh);
		bus(1, pattern_channel_pkg::OFF_DRIVE_EN, 32'hffff0000);
		// start clears every accumulator, so the run always begins at address zero
		acc = 0;
		for (int i = 0; i < n; i++) begin
			d = $urandom;
			if (all_fail) d[31:28] = 4'hf;
			c = card_rx(d, f, tim[15:12] < tim[11:8]);
			rx[i] = c[31:0];
			dt[i] = c[63:32];
			e = all_fail ? rx[i] ^ 32'h1 : rx[i] ^ ($urandom & 32'h0000_0303);
			bus(1, pattern_channel_pkg::OFF_MEM_INDEX, 32'((acc[7:0] + 8'(i)) & 8'hf));
			bus(1, pattern_channel_pkg::OFF_DRV_DATA, d);
			bus(1, pattern_channel_pkg::OFF_EXP_DATA, e);
			if (|((rx[i] ^ e) & ~inh & 32'h0000_ffff)) begin
				nf++;
				fa = {acc[31:8], acc[7:0] + 8'(i)};
				fd = rx[i];
			end
			if (|(rx[i] & dt[i] & 32'h0000_ffff)) nm++;
		end
		start_wait({25'h0, f, 4'h3});
		bus(0, pattern_channel_pkg::OFF_FAIL_COUNT, 0);
		chk(q, nf);
		bus(0, pattern_channel_pkg::OFF_NML_COUNT, 0);
		chk(q, nm);
		if (nf > 0) begin
			bus(0, pattern_channel_pkg::OFF_FAIL_ADDR, 0);
			chk(q, fa);
			bus(0, pattern_channel_pkg::OFF_FAIL_DATA, 0);
			chk(q, fd);
		end
		for (int i = 0; i < n; i++) begin
			bus(1, pattern_channel_pkg::OFF_MEM_INDEX, 32'((acc[7:0] + 8'(i)) & 8'hf));
			bus(0, pattern_channel_pkg::OFF_RES_DATA, 0);
			chk(q, rx[i]);
			bus(0, pattern_channel_pkg::OFF_DET_DATA, 0);
			chk(q, rx[i] & dt[i]);
		end
		st = 32'({nm > 0, nf > 0, 1'b1});
		chk(32'(irq), 32'(|(st & mask)));
		bus(0, pattern_channel_pkg::OFF_IRQ_STATUS, 0);
		chk(q, st);
		bus(0, pattern_channel_pkg::OFF_IRQ_STATUS, 0);
		chk(q, 0);
		chk(32'(irq), 0);
		read_accs();
		chk(acc, n);
	endtask
	initial begin
		void'($urandom(32'h0f23));
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		bus(0, pattern_channel_pkg::OFF_CTRL, 0);
		chk(q, pattern_channel_pkg::CTRL_RESET);
		bus(0, pattern_channel_pkg::OFF_TIMING, 0);
		chk(q, {16'h0, pattern_channel_pkg::TIMING_RESET});
		bus(0, pattern_channel_pkg::OFF_VEC_COUNT, 0);
		chk(q, {24'h0, pattern_channel_pkg::VEC_RESET});
		bus(1, 8'h3c, '1);
		bus(0, 8'h3c, 0);
		chk(q, 0);
		bus(1, pattern_channel_pkg::OFF_FAIL_COUNT, '1);
		bus(0, pattern_channel_pkg::OFF_FAIL_COUNT, 0);
		chk(q, 0);
		mask = 32'h7;
		bus(1, pattern_channel_pkg::OFF_IRQ_MASK, mask);
		bus(1, pattern_channel_pkg::OFF_ACC0, 32'({pattern_channel_pkg::SRC_TICK, 8'h01}));
		run(16, 3'h0, 16'h3804, 1, 0);
		run(16, 3'h0, 16'h3804, 1, 32'h1);
		// masked fail and nml events must not reach the interrupt
		mask = 32'h1;
		bus(1, pattern_channel_pkg::OFF_IRQ_MASK, mask);
		for (int f = 0; f < 8; f++) begin
			for (int t = 0; t < 2; t++) run(2, 3'(f), t ? 16'h6407 : 16'h2404, 0, 0);
		end
		repeat (4) run(1 + $urandom % 16, 3'($urandom), 16'h3804, 0, $urandom & 32'h0303);
		// carry chain: acc0 ticks, acc1 local, acc2 via looped global line, acc3 from acc2
		bus(1, pattern_channel_pkg::OFF_ACC0, 32'({pattern_channel_pkg::SRC_TICK, 8'h80}));
		bus(1, pattern_channel_pkg::OFF_ACC0 + 8'h4, 32'({pattern_channel_pkg::SRC_LOCAL, 8'h01}));
		bus(1, pattern_channel_pkg::OFF_ACC0 + 8'h8, 32'({pattern_channel_pkg::SRC_GLOBAL, 8'h80}));
		bus(1, pattern_channel_pkg::OFF_ACC3, 32'({pattern_channel_pkg::SRC_LOCAL + 4'h2, 8'h01}));
		bus(1, pattern_channel_pkg::OFF_VEC_COUNT, 8);
		acc = 0;
		p0 = pulses;
		ncar = 0;
		for (int t = 0; t < 8; t++) begin
			if (acc[7]) begin
				ncar++;
				// the run stops at the last tick, so that carry leaves but never ripples on
				if (t < 7) begin
					acc[15:8] = acc[15:8] + 8'h1;
					if (acc[23]) acc[31:24] = acc[31:24] + 8'h1;
					acc[23] = ~acc[23];
				end
			end
			acc[7] = ~acc[7];
		end
		mask = acc;
		start_wait(32'h3);
		chk(pulses - p0, ncar);
		read_accs();
		chk(acc, mask);
		end_of_test();
	end
endmodule
`default_nettype wire
